// ===== src/uhc_defs.vh
// register indices, field codes and reset values of the usb host channel block
`ifndef UHC_DEFS_VH
`define UHC_DEFS_VH
// ----------------------------------------------------------------
// register indices (byte address is index * 4)
// ----------------------------------------------------------------
`define UHC_IX_SETUP 9'h110
`define UHC_IX_CFG0 9'h120
`define UHC_IX_TK0 9'h121
`define UHC_IX_MPS0 9'h123
`define UHC_IX_BC0H 9'h118
`define UHC_IX_BC0L 9'h119
`define UHC_IX_HUB0 9'h128
`define UHC_IX_TGT0 9'h129
`define UHC_IX_CSEQ 9'h12B
`define UHC_IX_RES0 9'h12E
`define UHC_IX_CFGA0 9'h130
`define UHC_IX_CFGA1 9'h131
`define UHC_IX_MPSAH 9'h132
`define UHC_IX_MPSAL 9'h133
`define UHC_IX_BCA3 9'h134
`define UHC_IX_BCA2 9'h135
`define UHC_IX_BCA1 9'h136
`define UHC_IX_BCA0 9'h137
`define UHC_IX_ST0 9'h140
`define UHC_IX_STA 9'h141
// ----------------------------------------------------------------
// field codes
// ----------------------------------------------------------------
`define UHC_TK_SETUP 2'h0
`define UHC_TK_OUT 2'h1
`define UHC_TK_IN 2'h2
`define UHC_STG_IDLE 2'h0
`define UHC_STG_SETUP 2'h1
`define UHC_STG_DATA 2'h2
`define UHC_STG_STAT 2'h3
`define UHC_RC_CLEAN 3'h0
`define UHC_RC_STALL 3'h1
`define UHC_RC_OVER 3'h2
`define UHC_RC_UNDER 3'h3
`define UHC_RC_RETRY 3'h4
`define UHC_SETUP_LEN 16'h0008
`define UHC_RST_BYTE 8'h00
`endif

// ===== src/uhc_chan_ctrl.v
// usb host channel 0 control sequencer and bulk channel a control
//
// Summary of operation
// R01: channel 0 holds 16-bit byte count
// R02: byte count drops on each good transaction
// R03: zero byte count OUT sends one ZLP
// R04: hub, port, target, endpoint routing fields
// R05: stage field 00 idle, 01/10/11 stages
// R06: sequence run issues SETUP with eight bytes
// R07: data stage runs by direction and count
// R08: status stage token set by data stage
// R09: done flag on success, abort on error
// R10: sequence run bit clears itself at end
// R11: clearing run aborts in setup or data stage, stage stays visible
// R12: 3-bit result code in bits 6-4
// R13: overrun on oversize packet or total
// R14: short packet toggle mismatch is not overrun
// R15: underrun on short packet below count
// R16: retry error for link-level faults
// R17: channel a counts handshakes to target
// R18: software writes only valid speed codes
// R19: toggle bit seeds and tracks sequence
// R20: run starts, clear stops, halted flag
// R21: count done clears run; halt clears run
// R22: halt keeps count and settings for resume
// R23: auto ZLP after full last OUT packet
// R24: unbounded option ignores byte count
// R25: channel a token 01 OUT, 10 IN
// R26: channel 0 token 00 SETUP,01 OUT,10 IN
// R27: reserved bits read zero, ignore writes
//
// The Wishbone slave port is this design's own decision.
`timescale 1ns/1ns
`include "uhc_defs.vh"
module uhc_chan_ctrl (
   input wire core_clk,
   input wire reset_n,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [10:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output wire [31:0] wb_dat_o,
   output wire wb_ack_o,
   output wire x_req,
   output wire x_chan,
   output wire [1:0] x_token,
   output wire [15:0] x_len,
   output wire x_toggle,
   output wire [1:0] x_speed,
   output wire [7:0] x_hub,
   output wire [7:0] x_target,
   output wire [63:0] x_setup,
   input wire x_done,
   input wire x_stall,
   input wire x_timeout,
   input wire x_crc_err,
   input wire x_stuff_err,
   input wire x_pid_err,
   input wire x_toggle_bad,
   input wire [15:0] x_rx_len
);
localparam S_IDLE = 5'b00001;
localparam S_SET = 5'b00010;
localparam S_DAT = 5'b00100;
localparam S_STA = 5'b01000;
localparam S_RUN = 5'b10000;
// ----------------------------------------------------------------
// result classification
// ----------------------------------------------------------------
function [2:0] classify;
   input flt;
   input stall;
   input tbad;
   input is_in;
   input [15:0] rx;
   input [15:0] mps;
   input [15:0] rem;
   begin
      if (flt) begin
         classify = `UHC_RC_RETRY; // R16
      end else if (stall) begin
         classify = `UHC_RC_STALL;
      end else if (!is_in) begin
         classify = `UHC_RC_CLEAN;
      end else if (rx > mps) begin
         classify = `UHC_RC_OVER; // R13
      end else if (tbad) begin
         classify = `UHC_RC_RETRY; // R14
      end else if (rx > rem) begin
         classify = `UHC_RC_OVER; // R13
      end else if (rx < mps && rx < rem) begin
         classify = `UHC_RC_UNDER; // R15
      end else begin
         classify = `UHC_RC_CLEAN;
      end
   end
endfunction
reg ack_q;
reg [7:0] rd_q;
reg [7:0] rd_d;
reg [7:0] setup_q [0:7];
reg [15:0] bc0_q;
reg [7:0] hub0_q;
reg [7:0] tgt0_q;
reg [6:0] mps0_q;
reg [1:0] tk0_q;
reg [1:0] spd0_q;
reg tog0_q;
reg run0_q;
reg cs_run_q;
reg [1:0] stage_q;
reg dstage_q;
reg pend0_q;
reg [4:0] st0_q;
reg [2:0] res0_q;
reg cdone_q;
reg cabt_q;
reg bcd0_q;
reg [3:0] acka_q;
reg [1:0] spda_q;
reg toga_q;
reg runa_q;
reg stopa_q;
reg [1:0] tka_q;
reg zlp_q;
reg unb_q;
reg [9:0] mpsa_q;
reg [31:0] bca_q;
reg [4:0] cnta_q;
reg [2:0] resa_q;
reg hit_q;
reg bcda_q;
reg halt_q;
reg req_q;
reg chan_q;
reg [1:0] tok_q;
reg [15:0] len_q;
reg xtog_q;
integer i;
wire acc = wb_cyc_i & wb_stb_i & ~ack_q;
wire wr = acc & wb_we_i & wb_sel_i[0];
wire [8:0] ix = wb_adr_i[10:2];
wire [7:0] wd = wb_dat_i[7:0];
wire [15:0] mps0w = {9'h000, mps0_q};
wire [15:0] mpsaw = {6'h00, mpsa_q};
wire [15:0] pk0 = (bc0_q > mps0w) ? mps0w : bc0_q;
// unbounded or 64k and above: treat as plenty left, the packet size limits
wire [15:0] rema = (unb_q | (|bca_q[31:16])) ? 16'hFFFF : bca_q[15:0]; // R24
wire [15:0] pka = (rema > mpsaw) ? mpsaw : rema;
wire is_in = (tok_q == `UHC_TK_IN);
wire [15:0] moved = is_in ? x_rx_len : len_q;
wire flt = x_timeout | x_crc_err | x_stuff_err | x_pid_err;
wire [2:0] code = classify(flt, x_stall, x_toggle_bad, is_in, x_rx_len,
   chan_q ? mpsaw : mps0w, chan_q ? rema : bc0_q);
wire under = (code == `UHC_RC_UNDER);
wire cerr = (code != `UHC_RC_CLEAN) & ~under;
wire done0 = x_done & req_q & ~chan_q;
wire donea = x_done & req_q & chan_q;
wire [15:0] nbc0 = bc0_q - moved; // R02
wire [31:0] nbca = bca_q - {16'h0000, moved};
wire [4:0] tgta = {acka_q == 4'h0, acka_q}; // R17
wire [4:0] cnta_n = cnta_q + 5'h01;
wire ztail = zlp_q & ~is_in & (moved == mpsaw) & (moved != 16'h0000); // R23
wire want0 = ~st0_q[0] & ~(st0_q[4] & tk0_q == 2'h3);
wire wanta = runa_q & (tka_q == `UHC_TK_OUT | tka_q == `UHC_TK_IN); // R25
wire [1:0] dtok = setup_q[0][7] ? `UHC_TK_IN : `UHC_TK_OUT; // R07
wire [1:0] stok = (dstage_q & setup_q[0][7]) ? `UHC_TK_OUT : `UHC_TK_IN; // R08
reg [1:0] tok0;
reg [15:0] len0;
always @* begin
   case (st0_q)
      S_SET: begin
         tok0 = `UHC_TK_SETUP; // R06
         len0 = `UHC_SETUP_LEN;
      end
      S_DAT: begin
         tok0 = dtok;
         len0 = pk0;
      end
      S_STA: begin
         tok0 = stok;
         len0 = 16'h0000;
      end
      default: begin
         tok0 = tk0_q; // R26
         len0 = |tk0_q ? pk0 : `UHC_SETUP_LEN; // R03
      end
   endcase
end
assign wb_ack_o = ack_q;
assign wb_dat_o = {24'h000000, rd_q};
assign x_req = req_q;
assign x_chan = chan_q;
assign x_token = tok_q;
assign x_len = len_q;
assign x_toggle = xtog_q;
assign x_speed = chan_q ? spda_q : spd0_q;
assign x_hub = hub0_q;
assign x_target = tgt0_q;
genvar g;
generate
   for (g = 0; g < 8; g = g + 1) begin : g_setup
      assign x_setup[8*g+7:8*g] = setup_q[g];
   end
endgenerate
// ----------------------------------------------------------------
// register read mux
// ----------------------------------------------------------------
always @* begin
   rd_d = 8'h00;
   if (ix[8:3] == `UHC_IX_SETUP >> 3) begin
      rd_d = setup_q[ix[2:0]];
   end
   case (ix)
      `UHC_IX_BC0H: rd_d = bc0_q[15:8];
      `UHC_IX_BC0L: rd_d = bc0_q[7:0];
      `UHC_IX_CFG0: rd_d = {4'h0, spd0_q, tog0_q, run0_q};
      `UHC_IX_TK0: rd_d = {tk0_q, 6'h00};
      `UHC_IX_MPS0: rd_d = {1'b0, mps0_q};
      `UHC_IX_HUB0: rd_d = hub0_q;
      `UHC_IX_TGT0: rd_d = tgt0_q;
      `UHC_IX_CSEQ: rd_d = {2'h0, stage_q, 3'h0, cs_run_q}; // R05
      `UHC_IX_RES0: rd_d = {1'b0, res0_q, 4'h0}; // R12
      `UHC_IX_CFGA0: rd_d = {acka_q, spda_q, toga_q, runa_q}; // R20
      `UHC_IX_CFGA1: rd_d = {tka_q, 2'h0, zlp_q, 2'h0, unb_q}; // R27
      `UHC_IX_MPSAH: rd_d = {6'h00, mpsa_q[9:8]};
      `UHC_IX_MPSAL: rd_d = mpsa_q[7:0];
      `UHC_IX_BCA3: rd_d = bca_q[31:24];
      `UHC_IX_BCA2: rd_d = bca_q[23:16];
      `UHC_IX_BCA1: rd_d = bca_q[15:8];
      `UHC_IX_BCA0: rd_d = bca_q[7:0];
      `UHC_IX_ST0: rd_d = {5'h00, bcd0_q, cabt_q, cdone_q};
      `UHC_IX_STA: rd_d = {1'b0, resa_q, 1'b0, halt_q, bcda_q, hit_q};
      default: rd_d = rd_d;
   endcase
end
// sequence stops with the stage field frozen where it failed
task abort0;
   begin
      st0_q <= S_IDLE;
      cs_run_q <= 1'b0;
      cabt_q <= 1'b1;
      pend0_q <= 1'b0;
   end
endtask
// ----------------------------------------------------------------
// registers, sequencers and link request
// ----------------------------------------------------------------
always @(posedge core_clk or negedge reset_n) begin
   if (!reset_n) begin
      ack_q <= 1'b0;
      rd_q <= `UHC_RST_BYTE;
      for (i = 0; i < 8; i = i + 1) begin
         setup_q[i] <= `UHC_RST_BYTE;
      end
      bc0_q <= 16'h0000;
      hub0_q <= `UHC_RST_BYTE;
      tgt0_q <= `UHC_RST_BYTE;
      mps0_q <= 7'h00;
      tk0_q <= 2'h0;
      spd0_q <= 2'h0;
      tog0_q <= 1'b0;
      run0_q <= 1'b0;
      cs_run_q <= 1'b0;
      stage_q <= `UHC_STG_IDLE;
      dstage_q <= 1'b0;
      pend0_q <= 1'b0;
      st0_q <= S_IDLE;
      res0_q <= `UHC_RC_CLEAN;
      cdone_q <= 1'b0;
      cabt_q <= 1'b0;
      bcd0_q <= 1'b0;
      acka_q <= 4'h0;
      spda_q <= 2'h0;
      toga_q <= 1'b0;
      runa_q <= 1'b0;
      stopa_q <= 1'b0;
      tka_q <= 2'h0;
      zlp_q <= 1'b0;
      unb_q <= 1'b0;
      mpsa_q <= 10'h000;
      bca_q <= 32'h00000000;
      cnta_q <= 5'h00;
      resa_q <= `UHC_RC_CLEAN;
      hit_q <= 1'b0;
      bcda_q <= 1'b0;
      halt_q <= 1'b0;
      req_q <= 1'b0;
      chan_q <= 1'b0;
      tok_q <= 2'h0;
      len_q <= 16'h0000;
      xtog_q <= 1'b0;
   end else begin
      ack_q <= acc;
      rd_q <= rd_d;
      if (wr) begin
         if (ix[8:3] == `UHC_IX_SETUP >> 3) begin
            setup_q[ix[2:0]] <= wd;
         end
         case (ix)
            `UHC_IX_BC0H: bc0_q[15:8] <= wd; // R01
            `UHC_IX_BC0L: bc0_q[7:0] <= wd;
            `UHC_IX_CFG0: begin
               spd0_q <= wd[3:2];
               tog0_q <= wd[1];
               if (wd[0] && st0_q == S_IDLE) begin
                  st0_q <= S_RUN;
                  run0_q <= 1'b1;
               end else if (!wd[0] && st0_q == S_RUN) begin
                  if (req_q ? !chan_q : want0) begin
                     pend0_q <= 1'b1;
                  end else begin
                     st0_q <= S_IDLE;
                     run0_q <= 1'b0;
                  end
               end
            end
            `UHC_IX_TK0: tk0_q <= wd[7:6];
            `UHC_IX_MPS0: mps0_q <= wd[6:0];
            `UHC_IX_HUB0: hub0_q <= {wd[7:4], 1'b0, wd[2:0]}; // R04
            `UHC_IX_TGT0: tgt0_q <= wd; // R04
            `UHC_IX_CSEQ: begin
               if (wd[0] && st0_q == S_IDLE) begin
                  st0_q <= S_SET; // R06
                  stage_q <= `UHC_STG_SETUP;
                  cs_run_q <= 1'b1;
                  tog0_q <= 1'b0;
                  dstage_q <= 1'b0;
                  res0_q <= `UHC_RC_CLEAN;
               end else if (!wd[0] && cs_run_q) begin
                  pend0_q <= 1'b1; // R11
               end
            end
            `UHC_IX_CFGA0: begin
               acka_q <= wd[7:4];
               spda_q <= wd[3:2]; // R18
               toga_q <= wd[1]; // R19
               if (wd[0]) begin
                  runa_q <= 1'b1; // R22
                  stopa_q <= 1'b0;
               end else if (runa_q) begin
                  if (req_q ? chan_q : !want0 & wanta) begin
                     stopa_q <= 1'b1; // R20
                  end else begin
                     runa_q <= 1'b0;
                     halt_q <= 1'b1;
                  end
               end
            end
            `UHC_IX_CFGA1: begin
               tka_q <= wd[7:6];
               zlp_q <= wd[3];
               unb_q <= wd[0];
            end
            `UHC_IX_MPSAH: mpsa_q[9:8] <= wd[1:0];
            `UHC_IX_MPSAL: mpsa_q[7:0] <= wd;
            `UHC_IX_BCA3: bca_q[31:24] <= wd;
            `UHC_IX_BCA2: bca_q[23:16] <= wd;
            `UHC_IX_BCA1: bca_q[15:8] <= wd;
            `UHC_IX_BCA0: bca_q[7:0] <= wd;
            `UHC_IX_ST0: begin
               cdone_q <= cdone_q & ~wd[0];
               cabt_q <= cabt_q & ~wd[1];
               bcd0_q <= bcd0_q & ~wd[2];
            end
            `UHC_IX_STA: begin
               hit_q <= hit_q & ~wd[0];
               bcda_q <= bcda_q & ~wd[1];
               halt_q <= halt_q & ~wd[2];
            end
            default: ;
         endcase
      end
      // issue: channel 0 first, request held until the link reports done
      if (!req_q) begin
         if (want0) begin
            req_q <= 1'b1;
            chan_q <= 1'b0;
            tok_q <= tok0;
            len_q <= len0;
            xtog_q <= tog0_q & |tok0;
         end else if (wanta) begin
            req_q <= 1'b1;
            chan_q <= 1'b1;
            tok_q <= tka_q;
            len_q <= pka; // R03
            xtog_q <= toga_q; // R19
         end
      end else if (x_done) begin
         req_q <= 1'b0;
      end
      if (done0) begin
         res0_q <= code; // R12
         case (st0_q)
            S_SET: begin
               if (cerr || pend0_q) begin
                  abort0; // R09
               end else if (bc0_q != 16'h0000) begin
                  tog0_q <= 1'b1;
                  st0_q <= S_DAT; // R07
                  stage_q <= `UHC_STG_DATA;
                  dstage_q <= 1'b1;
               end else begin
                  tog0_q <= 1'b1;
                  st0_q <= S_STA;
                  stage_q <= `UHC_STG_STAT;
               end
            end
            S_DAT: begin
               if (cerr || pend0_q) begin
                  abort0;
               end else begin
                  bc0_q <= nbc0;
                  tog0_q <= ~tog0_q;
                  if (nbc0 == 16'h0000 || under) begin
                     tog0_q <= 1'b1;
                     st0_q <= S_STA; // R08
                     stage_q <= `UHC_STG_STAT;
                  end
               end
            end
            S_STA: begin
               if (cerr) begin
                  abort0;
               end else begin
                  st0_q <= S_IDLE;
                  stage_q <= `UHC_STG_IDLE;
                  cs_run_q <= 1'b0; // R10
                  cdone_q <= 1'b1; // R09
                  pend0_q <= 1'b0;
               end
            end
            S_RUN: begin
               pend0_q <= 1'b0;
               if (cerr || under || pend0_q) begin
                  st0_q <= S_IDLE;
                  run0_q <= 1'b0;
               end else begin
                  bc0_q <= nbc0; // R02
                  tog0_q <= ~tog0_q;
                  if (nbc0 == 16'h0000) begin
                     st0_q <= S_IDLE;
                     run0_q <= 1'b0;
                     bcd0_q <= 1'b1;
                  end
               end
            end
            default: st0_q <= S_IDLE;
         endcase
      end
      if (donea) begin
         resa_q <= code;
         stopa_q <= 1'b0;
         if (cerr || under) begin
            runa_q <= 1'b0; // R21
            halt_q <= 1'b1;
         end else begin
            toga_q <= ~toga_q; // R19
            if (!unb_q) begin
               bca_q <= nbca; // R24
            end
            if (cnta_n == tgta) begin
               hit_q <= 1'b1; // R17
               cnta_q <= 5'h00;
            end else begin
               cnta_q <= cnta_n;
            end
            if (!unb_q && nbca == 32'h00000000 && !ztail) begin
               runa_q <= 1'b0; // R21
               bcda_q <= 1'b1;
            end else if (stopa_q) begin
               runa_q <= 1'b0; // R20
               halt_q <= 1'b1; // R22
            end
         end
      end
   end
end
endmodule // uhc_chan_ctrl

// ===== sim/uhc_link_model.sv
// link partner model that answers channel transactions
`timescale 1ns/1ns
module uhc_link_model (
   input wire core_clk,
   input wire reset_n,
   input wire x_req,
   input wire [3:0] dly,
   input wire [5:0] fl,
   input wire [15:0] rxl,
   output wire x_done,
   output wire x_stall,
   output wire x_timeout,
   output wire x_crc_err,
   output wire x_stuff_err,
   output wire x_pid_err,
   output wire x_toggle_bad,
   output wire [15:0] x_rx_len
);
   reg [3:0] cnt_q;
   reg done_q;
   reg ph_q;
   // qualifiers mean nothing outside the done cycle, so they toggle there
   assign x_done = done_q;
   assign {x_stall, x_timeout, x_crc_err, x_stuff_err, x_pid_err, x_toggle_bad} =
      done_q ? fl : {6{ph_q}};
   assign x_rx_len = done_q ? rxl : {16{ph_q}};
   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_q <= 4'h0;
         done_q <= 1'b0;
         ph_q <= 1'b0;
      end else begin
         ph_q <= ~ph_q;
         done_q <= 1'b0;
         if (x_req && !done_q) begin
            if (cnt_q >= dly) begin
               done_q <= 1'b1;
               cnt_q <= 4'h0;
            end else begin
               cnt_q <= cnt_q + 4'h1;
            end
         end
      end
   end
endmodule // uhc_link_model

// ===== sim/uhc_chan_ctrl_asserts.sv
// concurrent checks on the ports of the usb host channel block
`timescale 1ns/1ns
`include "uhc_defs.vh"
module uhc_asserts (
   input wire core_clk,
   input wire reset_n,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [10:0] wb_adr_i,
   input wire [31:0] wb_dat_o,
   input wire wb_ack_o,
   input wire x_req,
   input wire x_chan,
   input wire [1:0] x_token,
   input wire [15:0] x_len,
   input wire x_toggle,
   input wire x_done
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   wire rd = wb_ack_o && !wb_we_i;
   wire [8:0] ix = wb_adr_i[10:2];
   ack_pulse_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
      else $error("bus ack is not a one cycle answer");
   upper_zero_a: assert property (rd |-> wb_dat_o[31:8] == 24'h000000)
      else $error("read data upper bits not zero");
   result_rsvd_a: assert property (rd && ix == `UHC_IX_RES0 |-> (wb_dat_o[7:0] & 8'h8F) == 8'h00)
      else $error("result register reserved bits set");
   hub_rsvd_a: assert property (rd && ix == `UHC_IX_HUB0 |-> !wb_dat_o[3])
      else $error("hub register bit 3 set");
   seq_rsvd_a: assert property (rd && ix == `UHC_IX_CSEQ |-> (wb_dat_o[7:0] & 8'hCE) == 8'h00)
      else $error("sequencer register reserved bits set");
   req_hold_a: assert property (x_req && !x_done |=> x_req && $stable(x_token)
      && $stable(x_len) && $stable(x_toggle) && $stable(x_chan))
      else $error("request changed before its answer");
   req_drop_a: assert property (x_req && x_done |=> !x_req)
      else $error("request not released after answer");
   token_legal_a: assert property (x_req |-> x_token != 2'h3)
      else $error("reserved token issued");
   cha_token_a: assert property (x_req && x_chan |-> x_token == `UHC_TK_OUT || x_token == `UHC_TK_IN)
      else $error("channel a token not out or in");
   setup_len_a: assert property (x_req && x_token == `UHC_TK_SETUP |->
      x_len == `UHC_SETUP_LEN && !x_toggle && !x_chan)
      else $error("setup transaction not eight bytes data0");
   setup_cv: cover property (x_req && x_token == `UHC_TK_SETUP);
   cha_cv: cover property (x_req && x_chan && x_done);
   result_cv: cover property (rd && ix == `UHC_IX_RES0);
endmodule // uhc_asserts
bind uhc_chan_ctrl uhc_asserts uhc_asserts_inst (.core_clk(core_clk), .reset_n(reset_n),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .x_req(x_req), .x_chan(x_chan),
   .x_token(x_token), .x_len(x_len), .x_toggle(x_toggle), .x_done(x_done));

// ===== sim/usb_host_channel_control_tb_top.sv
// self-checking bench for the usb host channel block
`timescale 1ns/1ns
`include "uhc_defs.vh"
module usb_host_channel_control_tb_top;
   reg core_clk = 1'b0;
   reg reset_n = 1'b0;
   reg wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   reg [10:0] wb_adr_i = 11'h000;
   reg [3:0] wb_sel_i = 4'hF;
   reg [31:0] wb_dat_i = 32'h00000000;
   reg [3:0] dly = 4'h8;
   reg [5:0] fl = 6'h00;
   reg [15:0] rxl = 16'h0000;
   reg [31:0] rdat;
   wire [31:0] wb_dat_o;
   wire [63:0] x_setup;
   wire [15:0] x_len, x_rx_len;
   wire [7:0] x_hub, x_target;
   wire [1:0] x_token, x_speed;
   wire wb_ack_o, x_req, x_chan, x_toggle, x_done, x_stall, x_timeout;
   wire x_crc_err, x_stuff_err, x_pid_err, x_toggle_bad;
   integer miscompares = 0, comparisons = 0, i;
   logic [24:0] regt [0:7] = '{{`UHC_IX_HUB0, 8'hFF, 8'hF7}, {`UHC_IX_TGT0, 8'hA5, 8'hA5},
      {`UHC_IX_BC0H, 8'h12, 8'h12}, {`UHC_IX_BC0L, 8'h34, 8'h34}, {`UHC_IX_MPS0, 8'hFF, 8'h7F},
      {`UHC_IX_RES0, 8'hFF, 8'h00}, {`UHC_IX_CFGA1, 8'h36, 8'h00}, {9'h1FF, 8'hFF, 8'h00}};
   // flags {stall, timeout, crc, stuff, pid, toggle}, received length, result code
   logic [24:0] errt [0:9] = '{{6'h20, 16'h0000, 3'h1}, {6'h10, 16'h0000, 3'h4},
      {6'h08, 16'h0008, 3'h4}, {6'h04, 16'h0008, 3'h4}, {6'h02, 16'h0008, 3'h4},
      {6'h01, 16'h0004, 3'h4}, {6'h00, 16'h0009, 3'h2}, {6'h0C, 16'h0009, 3'h4},
      {6'h0C, 16'h0004, 3'h4}, {6'h00, 16'h0004, 3'h3}};
   uhc_chan_ctrl uhc_chan_ctrl_inst (.*);
   uhc_link_model uhc_link_model_inst (.*);
   initial begin
      forever #20 core_clk = ~core_clk;
   end
   // ------
   // tasks
   // ------
   task chk(input [31:0] s, input [31:0] e);
      begin
         comparisons = comparisons + 1;
         if (s !== e) begin
            miscompares = miscompares + 1;
            $display("mismatch at %0t: saw %h want %h", $time, s, e);
         end
      end
   endtask
   task bus(input w, input [8:0] a, input [7:0] d);
      integer n;
      begin
         wb_cyc_i <= 1'b1;
         wb_stb_i <= 1'b1;
         wb_we_i <= w;
         wb_adr_i <= {a, 2'h0};
         wb_dat_i <= {24'h000000, d};
         n = 0;
         @(posedge core_clk);
         while (wb_ack_o !== 1'b1 && n < 20) begin
            @(posedge core_clk);
            n = n + 1;
         end
         rdat = wb_dat_o;
         wb_cyc_i <= 1'b0;
         wb_stb_i <= 1'b0;
         wb_we_i <= 1'b0;
         @(posedge core_clk);
         if (n >= 20)
            chk(32'h0, 32'h1);
      end
   endtask
   task cr(input [8:0] a, input [7:0] e);
      begin
         bus(1'b0, a, 8'h00);
         chk(rdat, {24'h000000, e});
      end
   endtask
   // a length of FFFF means the expected length is left open
   task xact(input [1:0] t, input c, input [15:0] l, input g, input [5:0] f, input [15:0] r);
      integer n;
      begin
         fl <= f;
         rxl <= r;
         n = 0;
         while (x_req !== 1'b1 && n < 300) begin
            @(posedge core_clk);
            n = n + 1;
         end
         chk(x_token, t);
         chk(x_chan, c);
         chk(x_toggle, g);
         if (l !== 16'hFFFF)
            chk(x_len, l);
         while (x_req === 1'b1 && n < 300) begin
            @(posedge core_clk);
            n = n + 1;
         end
         if (n >= 300)
            chk(32'h0, 32'h1);
      end
   endtask
   task idle_chk;
      begin
         repeat (20) @(posedge core_clk);
         chk(x_req, 1'b0);
      end
   endtask
   task close_out;
      begin
         $display("counts: %0d comparisons, %0d miscompares", comparisons, miscompares);
         if (miscompares == 0 && comparisons > 0)
            $display("TB: PASS");
         else
            $display("TB: FAIL");
         $finish;
      end
   endtask
   initial begin
      repeat (20000) @(posedge core_clk);
      miscompares = miscompares + 1;
      close_out;
   end
   // ------
   // sequence
   // ------
   initial begin
      repeat (20) @(posedge core_clk);
      reset_n <= 1'b1;
      @(posedge core_clk);
      for (i = 0; i < 8; i = i + 1) begin
         cr(regt[i][24:16], 8'h00);
         bus(1'b1, regt[i][24:16], regt[i][15:8]);
         cr(regt[i][24:16], regt[i][7:0]);
      end
      $display("done: registers");
      for (i = 0; i < 8; i = i + 1)
         bus(1'b1, `UHC_IX_SETUP + i[8:0], (i == 0) ? 8'h80 : i[7:0]);
      bus(1'b1, `UHC_IX_BC0H, 8'h00);
      bus(1'b1, `UHC_IX_BC0L, 8'h10);
      bus(1'b1, `UHC_IX_MPS0, 8'h40);
      bus(1'b1, `UHC_IX_HUB0, 8'h53);
      bus(1'b1, `UHC_IX_CSEQ, 8'h01);
      xact(`UHC_TK_SETUP, 1'b0, `UHC_SETUP_LEN, 1'b0, 6'h00, 16'h0000);
      chk({x_setup[63:56], x_setup[7:0]}, 16'h0780);
      chk({x_hub, x_target}, 16'h53A5);
      cr(`UHC_IX_CSEQ, 8'h21);
      xact(`UHC_TK_IN, 1'b0, 16'hFFFF, 1'b1, 6'h00, 16'h0010);
      xact(`UHC_TK_OUT, 1'b0, 16'h0000, 1'b1, 6'h00, 16'h0000);
      cr(`UHC_IX_ST0, 8'h01);
      cr(`UHC_IX_CSEQ, 8'h00);
      cr(`UHC_IX_RES0, 8'h00);
      $display("done: control in");
      bus(1'b1, `UHC_IX_ST0, 8'hFF);
      bus(1'b1, `UHC_IX_SETUP, 8'h00);
      bus(1'b1, `UHC_IX_BC0L, 8'h04);
      bus(1'b1, `UHC_IX_CSEQ, 8'h01);
      xact(`UHC_TK_SETUP, 1'b0, `UHC_SETUP_LEN, 1'b0, 6'h00, 16'h0000);
      xact(`UHC_TK_OUT, 1'b0, 16'h0004, 1'b1, 6'h20, 16'h0000);
      cr(`UHC_IX_ST0, 8'h02);
      cr(`UHC_IX_RES0, 8'h10);
      bus(1'b0, `UHC_IX_CSEQ, 8'h00);
      chk(rdat[0], 1'b0);
      bus(1'b1, `UHC_IX_ST0, 8'hFF);
      bus(1'b1, `UHC_IX_CSEQ, 8'h01);
      bus(1'b1, `UHC_IX_CSEQ, 8'h00);
      xact(`UHC_TK_SETUP, 1'b0, `UHC_SETUP_LEN, 1'b0, 6'h00, 16'h0000);
      idle_chk;
      cr(`UHC_IX_ST0, 8'h02);
      cr(`UHC_IX_CSEQ, 8'h10);
      $display("done: control error and abort");
      bus(1'b1, `UHC_IX_TK0, 8'h40);
      bus(1'b1, `UHC_IX_BC0L, 8'h00);
      bus(1'b1, `UHC_IX_CFG0, 8'h01);
      xact(`UHC_TK_OUT, 1'b0, 16'h0000, 1'b0, 6'h00, 16'h0000);
      idle_chk;
      bus(1'b1, `UHC_IX_ST0, 8'hFF);
      bus(1'b1, `UHC_IX_TK0, 8'h80);
      bus(1'b1, `UHC_IX_MPS0, 8'h08);
      bus(1'b1, `UHC_IX_BC0L, 8'h10);
      bus(1'b1, `UHC_IX_CFG0, 8'h01);
      xact(`UHC_TK_IN, 1'b0, 16'hFFFF, 1'b0, 6'h00, 16'h0008);
      cr(`UHC_IX_BC0L, 8'h08);
      xact(`UHC_TK_IN, 1'b0, 16'hFFFF, 1'b1, 6'h00, 16'h0008);
      cr(`UHC_IX_ST0, 8'h04);
      cr(`UHC_IX_CFG0, 8'h00);
      dly <= 4'h1;
      for (i = 0; i < 10; i = i + 1) begin
         bus(1'b1, `UHC_IX_BC0L, 8'h10);
         bus(1'b1, `UHC_IX_CFG0, 8'h01);
         xact(`UHC_TK_IN, 1'b0, 16'hFFFF, 1'b0, errt[i][24:19], errt[i][18:3]);
         cr(`UHC_IX_RES0, {1'b0, errt[i][2:0], 4'h0});
      end
      $display("done: channel 0 results");
      dly <= 4'h8;
      bus(1'b1, `UHC_IX_BCA0, 8'h20);
      bus(1'b1, `UHC_IX_MPSAL, 8'h10);
      bus(1'b1, `UHC_IX_CFGA1, 8'h48);
      bus(1'b1, `UHC_IX_CFGA0, 8'h27);
      xact(`UHC_TK_OUT, 1'b1, 16'h0010, 1'b1, 6'h00, 16'h0000);
      cr(`UHC_IX_STA, 8'h00);
      xact(`UHC_TK_OUT, 1'b1, 16'h0010, 1'b0, 6'h00, 16'h0000);
      xact(`UHC_TK_OUT, 1'b1, 16'h0, 1'b1, 6'h0, 16'h0);
      cr(`UHC_IX_STA, 8'h03);
      cr(`UHC_IX_CFGA0, 8'h24);
      chk(x_speed, 2'h1);
      bus(1'b1, `UHC_IX_STA, 8'hFF);
      bus(1'b1, `UHC_IX_BCA0, 8'h30);
      bus(1'b1, `UHC_IX_CFGA0, 8'h07);
      bus(1'b1, `UHC_IX_CFGA0, 8'h06);
      xact(`UHC_TK_OUT, 1'b1, 16'h0010, 1'b1, 6'h00, 16'h0000);
      idle_chk;
      cr(`UHC_IX_STA, 8'h04);
      cr(`UHC_IX_BCA0, 8'h20);
      cr(`UHC_IX_CFGA0, 8'h04);
      bus(1'b1, `UHC_IX_CFGA0, 8'h05);
      xact(`UHC_TK_OUT, 1'b1, 16'h0010, 1'b0, 6'h00, 16'h0000);
      xact(`UHC_TK_OUT, 1'b1, 16'h0010, 1'b1, 6'h00, 16'h0000);
      xact(`UHC_TK_OUT, 1'b1, 16'h0, 1'b0, 6'h0, 16'h0);
      cr(`UHC_IX_STA, 8'h06);
      $display("done: channel a");
      bus(1'b1, `UHC_IX_BCA0, 8'h20);
      bus(1'b1, `UHC_IX_CFGA0, 8'h05);
      // reset lands while a transaction is in flight
      reset_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      reset_n <= 1'b1;
      @(posedge core_clk);
      cr(`UHC_IX_CFGA0, 8'h00);
      cr(`UHC_IX_HUB0, 8'h00);
      bus(1'b1, `UHC_IX_TK0, 8'hC0);
      bus(1'b1, `UHC_IX_CFG0, 8'h01);
      idle_chk;
      $display("done: reset and reserved token");
      close_out;
   end
endmodule // usb_host_channel_control_tb_top
